// ### verilog/processor_companion_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_params.svh"

module processor_companion_supervisor
#(
  parameter int HOLD_CYCLES     = `RST_HOLD_MS * `CYC_PER_MS,
  parameter int WD_UNIT_CYCLES  = `WD_UNIT_MS * `CYC_PER_MS,
  parameter int DEBOUNCE_CYCLES = `MR_DEBOUNCE_MS * `CYC_PER_MS,
  parameter int CAL_HALF_CYCLES = `CLK_HZ / (2 * `CAL_HZ)
)
(
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        ARST_N_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // open-drain reset pin
  input  wire logic        RST_I,
  output logic             RST_O,
  output logic             RST_OE_N_O,
  // supply monitor
  input  wire logic        LOW_SUPPLY_I,
  output logic      [1:0]  TRIP_SEL_O,
  // power-fail comparator
  input  wire logic        POWERFAIL_COMPARE_IN_I,
  output logic             POWERFAIL_WARN_OUT_O,
  // event inputs
  input  wire logic        EVENT_IN_ONE_I,
  input  wire logic        EVENT_IN_TWO_I,
  // interrupt
  output logic             IRQ_O
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // ************************************************************
  // pin synchronisers and event counters
  // ************************************************************
  logic [4:0]             sync_level;
  logic                   pin_level;
  logic                   low_level;
  logic                   pf_level;
  supervisor_pkg::count_t count_one;
  supervisor_pkg::count_t count_two;

  // reset pin idles high through its pull-up
  pin_sync
  #(
    .WIDTH (5),
    .INIT  (5'h10)
  )
  u_sync
  (
    .clk_i    (CLOCK_I),
    .arst_n_i (ARST_N_I),
    .pin_i    ({RST_I, LOW_SUPPLY_I, POWERFAIL_COMPARE_IN_I,
                EVENT_IN_TWO_I, EVENT_IN_ONE_I}),
    .level_o  (sync_level)
  );

  assign pin_level = sync_level[4];
  assign low_level = sync_level[3];
  assign pf_level  = sync_level[2];

  logic [10:0] ctrl;

  event_counter u_count_one
  (
    .clk_i     (CLOCK_I),
    .arst_n_i  (ARST_N_I),
    .level_i   (sync_level[0]),
    .falling_i (ctrl[`CTRL_POL1_BIT]),
    .count_o   (count_one)
  );

  event_counter u_count_two
  (
    .clk_i     (CLOCK_I),
    .arst_n_i  (ARST_N_I),
    .level_i   (sync_level[1]),
    .falling_i (ctrl[`CTRL_POL2_BIT]),
    .count_o   (count_two)
  );

  // ************************************************************
  // apb access decode
  // ************************************************************
  logic access;
  logic wr;
  logic rd;
  logic mapped;

  // a transfer completes on the edge where our pready is high
  always_comb
  begin
    access = PSEL_I & PENABLE_I & PREADY_O;
    wr     = access & PWRITE_I;
    rd     = access & ~PWRITE_I;
    mapped = reg_hit(PADDR_I, `OFS_CTRL) | reg_hit(PADDR_I, `OFS_WD_RESTART)
           | reg_hit(PADDR_I, `OFS_STATUS) | reg_hit(PADDR_I, `OFS_MASK)
           | reg_hit(PADDR_I, `OFS_FLAGS)
           | reg_hit(PADDR_I, `OFS_COUNT_ONE)
           | reg_hit(PADDR_I, `OFS_COUNT_TWO)
           | reg_hit(PADDR_I, `OFS_SERIAL_LO)
           | reg_hit(PADDR_I, `OFS_SERIAL_HI);
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic                  lock;
  logic [3:0]            mask;
  logic [63:0]           serial;
  logic [10:0]           next_ctrl;
  logic                  next_lock;
  logic [3:0]            next_mask;
  logic [63:0]           next_serial;
  logic                  wd_restart_wr;

  always_comb
  begin
    next_ctrl     = ctrl;
    next_lock     = lock;
    next_mask     = mask;
    next_serial   = serial;
    wd_restart_wr = wr & reg_hit(PADDR_I, `OFS_WD_RESTART);
    if (wr & reg_hit(PADDR_I, `OFS_CTRL))
    begin
      next_ctrl = PWDATA_I[10:0];
      // lock only sets; nothing but reset reopens the serial
      next_lock = lock | PWDATA_I[`CTRL_LOCK_BIT];
    end
    if (wr & reg_hit(PADDR_I, `OFS_MASK))
      next_mask = PWDATA_I[3:0];
    if (wr & ~lock & reg_hit(PADDR_I, `OFS_SERIAL_LO))
      next_serial[31:0] = PWDATA_I;
    if (wr & ~lock & reg_hit(PADDR_I, `OFS_SERIAL_HI))
      next_serial[63:32] = PWDATA_I;
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ctrl   <= `CTRL_RST;
      lock   <= 1'b0;
      mask   <= 4'h0;
      serial <= `SERIAL_RST;
    end
    else
    begin
      ctrl   <= next_ctrl;
      lock   <= next_lock;
      mask   <= next_mask;
      serial <= next_serial;
    end
  end

  // ************************************************************
  // watchdog
  // ************************************************************
  logic [31:0] wd_cyc;
  logic [4:0]  wd_units;
  logic [31:0] next_wd_cyc;
  logic [4:0]  next_wd_units;
  logic [4:0]  wd_period;
  logic        wd_restart;
  logic        wd_unit_end;
  logic        wd_timeout;
  logic        rst_active;

  // period in 100 ms units, clamped to 1..30
  always_comb
  begin
    wd_period = ctrl[`CTRL_WD_PER_MSB:`CTRL_WD_PER_LSB];
    if (wd_period < `WD_MIN_UNITS)
      wd_period = `WD_MIN_UNITS;
    else if (wd_period > `WD_MAX_UNITS)
      wd_period = `WD_MAX_UNITS;
    // held in restart while disabled or while reset is driven
    wd_restart  = wd_restart_wr | ~ctrl[`CTRL_WD_EN_BIT] | rst_active;
    wd_unit_end = (wd_cyc == 32'(WD_UNIT_CYCLES - 1));
    wd_timeout  = ~wd_restart & wd_unit_end
                & (5'(wd_units + 5'h01) == wd_period);
    next_wd_cyc   = wd_cyc;
    next_wd_units = wd_units;
    if (wd_restart | wd_timeout)
    begin
      next_wd_cyc   = 32'h0000_0000;
      next_wd_units = 5'h00;
    end
    else if (wd_unit_end)
    begin
      next_wd_cyc   = 32'h0000_0000;
      next_wd_units = 5'(wd_units + 5'h01);
    end
    else
      next_wd_cyc = 32'(wd_cyc + 32'h0000_0001);
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      wd_cyc   <= 32'h0000_0000;
      wd_units <= 5'h00;
    end
    else
    begin
      wd_cyc   <= next_wd_cyc;
      wd_units <= next_wd_units;
    end
  end

  // ************************************************************
  // reset sequencer and manual reset debounce
  // ************************************************************
  supervisor_pkg::rst_state_t state;
  supervisor_pkg::rst_state_t next_state;
  logic [31:0]                hold_cnt;
  logic [31:0]                next_hold_cnt;
  logic [31:0]                deb_cnt;
  logic [31:0]                next_deb_cnt;
  logic                       mr_trigger;
  logic                       next_oe_n;

  always_comb
  begin
    // our own drive reads back low, so only look while released
    next_deb_cnt = 32'h0000_0000;
    mr_trigger   = 1'b0;
    if ((state == supervisor_pkg::RS_IDLE) & ~pin_level)
    begin
      if (deb_cnt == 32'(DEBOUNCE_CYCLES - 1))
        mr_trigger = 1'b1;
      else
        next_deb_cnt = 32'(deb_cnt + 32'h0000_0001);
    end
    next_state    = state;
    next_hold_cnt = hold_cnt;
    unique case (state)
      supervisor_pkg::RS_IDLE:
      begin
        if (low_level | wd_timeout | mr_trigger)
        begin
          next_state    = supervisor_pkg::RS_HOLD;
          next_hold_cnt = 32'h0000_0000;
        end
      end
      supervisor_pkg::RS_HOLD:
      begin
        // the hold time restarts while supply is still low
        if (low_level)
          next_hold_cnt = 32'h0000_0000;
        else if (hold_cnt == 32'(HOLD_CYCLES - 1))
          next_state = supervisor_pkg::RS_IDLE;
        else
          next_hold_cnt = 32'(hold_cnt + 32'h0000_0001);
      end
    endcase
    next_oe_n = (next_state != supervisor_pkg::RS_HOLD);
  end

  assign rst_active = ~RST_OE_N_O;

  // power-up starts with a full hold time
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state      <= supervisor_pkg::RS_HOLD;
      hold_cnt   <= 32'h0000_0000;
      deb_cnt    <= 32'h0000_0000;
      RST_OE_N_O <= 1'b0;
      RST_O      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      hold_cnt   <= next_hold_cnt;
      deb_cnt    <= next_deb_cnt;
      RST_OE_N_O <= next_oe_n;
      RST_O      <= 1'b0; // open drain only ever pulls low
    end
  end

  // ************************************************************
  // source flags and interrupt status
  // ************************************************************
  logic                         pf_prev;
  logic                         low_prev;
  logic [2:0]                   flags;
  logic [2:0]                   next_flags;
  supervisor_pkg::event_t       status;
  supervisor_pkg::event_t       next_status;
  supervisor_pkg::event_t       events;
  logic                         next_irq;

  // set wins over clear on the same edge
  always_comb
  begin
    events                = 4'h0;
    events[`EV_PF_BIT]    = pf_level & ~pf_prev;
    events[`EV_WD_BIT]    = wd_timeout;
    events[`EV_LOW_BIT]   = low_level & ~low_prev;
    events[`EV_MR_BIT]    = mr_trigger;
    next_flags = flags;
    if (wr & reg_hit(PADDR_I, `OFS_FLAGS))
      next_flags = flags & ~PWDATA_I[2:0];
    next_flags = next_flags | {mr_trigger, low_level, wd_timeout};
    next_status = status;
    if (rd & reg_hit(PADDR_I, `OFS_STATUS))
      next_status = 4'h0;
    next_status = next_status | events;
    next_irq    = |(next_status & mask);
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pf_prev  <= 1'b0;
      low_prev <= 1'b0;
      flags    <= 3'h0;
      status   <= 4'h0;
      IRQ_O    <= 1'b0;
    end
    else
    begin
      pf_prev  <= pf_level;
      low_prev <= low_level;
      flags    <= next_flags;
      status   <= next_status;
      IRQ_O    <= next_irq;
    end
  end

  // ************************************************************
  // warn pin, calibration square wave, trip select
  // ************************************************************
  logic [31:0] cal_cnt;
  logic [31:0] next_cal_cnt;
  logic        cal_wave;
  logic        next_cal_wave;
  logic        next_warn;

  // the square wave only runs in calibration to save toggling
  always_comb
  begin
    next_cal_cnt  = 32'h0000_0000;
    next_cal_wave = 1'b0;
    if (ctrl[`CTRL_CAL_BIT])
    begin
      next_cal_wave = cal_wave;
      if (cal_cnt == 32'(CAL_HALF_CYCLES - 1))
        next_cal_wave = ~cal_wave;
      else
        next_cal_cnt = 32'(cal_cnt + 32'h0000_0001);
    end
    next_warn = ctrl[`CTRL_CAL_BIT] ? cal_wave : pf_level;
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cal_cnt              <= 32'h0000_0000;
      cal_wave             <= 1'b0;
      POWERFAIL_WARN_OUT_O <= 1'b0;
      TRIP_SEL_O           <= 2'h0;
    end
    else
    begin
      cal_cnt              <= next_cal_cnt;
      cal_wave             <= next_cal_wave;
      POWERFAIL_WARN_OUT_O <= next_warn;
      TRIP_SEL_O           <= ctrl[`CTRL_TRIP_MSB:`CTRL_TRIP_LSB];
    end
  end

  // ************************************************************
  // apb answer: one wait state, data latched with pready
  // ************************************************************
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb
  begin
    next_pready  = PSEL_I & PENABLE_I & ~PREADY_O;
    next_pslverr = next_pready & ~mapped;
    next_prdata  = 32'h0000_0000;
    if (next_pready & ~PWRITE_I)
    begin
      if (reg_hit(PADDR_I, `OFS_CTRL))
        next_prdata = {20'h00000, lock, ctrl};
      else if (reg_hit(PADDR_I, `OFS_STATUS))
        next_prdata = {28'h0000000, status};
      else if (reg_hit(PADDR_I, `OFS_MASK))
        next_prdata = {28'h0000000, mask};
      else if (reg_hit(PADDR_I, `OFS_FLAGS))
        next_prdata = {26'h0, lock, rst_active, pf_level, flags};
      else if (reg_hit(PADDR_I, `OFS_COUNT_ONE))
        next_prdata = {16'h0000, count_one};
      else if (reg_hit(PADDR_I, `OFS_COUNT_TWO))
        next_prdata = {16'h0000, count_two};
      else if (reg_hit(PADDR_I, `OFS_SERIAL_LO))
        next_prdata = serial[31:0];
      else if (reg_hit(PADDR_I, `OFS_SERIAL_HI))
        next_prdata = serial[63:32];
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PRDATA_O  <= next_prdata;
      PREADY_O  <= next_pready;
      PSLVERR_O <= next_pslverr;
    end
  end

endmodule : processor_companion_supervisor

`default_nettype wire

// ### verilog/supervisor_params.svh
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define CLK_HZ          20000000
`define CYC_PER_MS      (`CLK_HZ / 1000)
`define RST_HOLD_MS     100
`define WD_UNIT_MS      100
`define WD_MIN_UNITS    5'h01
`define WD_MAX_UNITS    5'h1e
`define MR_DEBOUNCE_MS  10
`define CAL_HZ          512

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_CTRL        8'h00
`define OFS_WD_RESTART  8'h04
`define OFS_STATUS      8'h08
`define OFS_MASK        8'h0c
`define OFS_FLAGS       8'h10
`define OFS_COUNT_ONE   8'h14
`define OFS_COUNT_TWO   8'h18
`define OFS_SERIAL_LO   8'h1c
`define OFS_SERIAL_HI   8'h20

// ************************************************************
// control fields
// ************************************************************
`define CTRL_WD_EN_BIT  0
`define CTRL_WD_PER_LSB 1
`define CTRL_WD_PER_MSB 5
`define CTRL_POL1_BIT   6
`define CTRL_POL2_BIT   7
`define CTRL_CAL_BIT    8
`define CTRL_TRIP_LSB   9
`define CTRL_TRIP_MSB   10
`define CTRL_LOCK_BIT   11
`define CTRL_RST        11'h002

// ************************************************************
// status (interrupt) and source flag fields
// ************************************************************
`define EV_PF_BIT       0
`define EV_WD_BIT       1
`define EV_LOW_BIT      2
`define EV_MR_BIT       3
`define FLG_PF_LIVE_BIT 3
`define FLG_RST_BIT     4
`define FLG_LOCK_BIT    5
`define SERIAL_RST      64'h0000_0000_0000_0000

`endif

// ### verilog/supervisor_pkg.sv
package supervisor_pkg;

  // reset sequencer states, gray along idle -> hold
  typedef enum logic [1:0]
  {
    RS_IDLE = 2'b00,
    RS_HOLD = 2'b01
  } rst_state_t;

  typedef logic [15:0] count_t;
  typedef logic [3:0]  event_t;

endpackage : supervisor_pkg

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
  parameter int                WIDTH = 1,
  parameter logic [WIDTH-1:0]  INIT  = '0
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // pins and clean levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;
  logic [WIDTH-1:0] agree;

  // a bit moves only once stages two and three agree
  always_comb
  begin
    agree      = ~(s2 ^ s3);
    next_level = (agree & s3) | (~agree & level_o);
  end

  // ************************************************************
  // three-stage chain, first stage read by the second only
  // ************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1      <= INIT;
      s2      <= INIT;
      s3      <= INIT;
      level_o <= INIT;
    end
    else
    begin
      s1      <= pin_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= next_level;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ### verilog/event_counter.sv
`timescale 1ns/1ps
`default_nettype none

module event_counter
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  // clean input level and edge choice
  input  wire logic                   level_i,
  input  wire logic                   falling_i,
  // running count
  output supervisor_pkg::count_t      count_o
);

  logic                   prev;
  logic                   hit;
  supervisor_pkg::count_t next_count;

  // one count per chosen edge; wraps at the top
  always_comb
  begin
    hit        = falling_i ? (prev & ~level_i) : (~prev & level_i);
    next_count = hit ? 16'(count_o + 16'h0001) : count_o;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev    <= 1'b0;
      count_o <= 16'h0000;
    end
    else
    begin
      prev    <= level_i;
      count_o <= next_count;
    end
  end

endmodule : event_counter

`default_nettype wire

// ### dv/reset_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// host side of the reset pin
// ********************************
module reset_line_model
(
  // device drive, low = pulling
  input  wire logic drive_n_i,
  // host pushbutton
  input  wire logic press_i,
  // resolved wire
  output logic      pin_o
);
  // weak pull-up wins only when nobody pulls low
  assign pin_o = (!drive_n_i || press_i) ? 1'b0 : 1'b1;
endmodule : reset_line_model
`default_nettype wire

// ### dv/supervisor_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// port checker
// ********************************
module supervisor_chk
#(
  parameter int HOLD_CYCLES     = 20,
  parameter int DEBOUNCE_CYCLES = 16
)
(
  // watched ports
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic RST_I,
  input wire logic RST_O,
  input wire logic RST_OE_N_O,
  input wire logic LOW_SUPPLY_I,
  input wire logic POWERFAIL_COMPARE_IN_I,
  input wire logic POWERFAIL_WARN_OUT_O
);
  int hold_cnt;
  int mr_cnt;

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);

  // low time of the drive, and pin-low time while not driving
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      hold_cnt <= 0;
      mr_cnt   <= 0;
    end
    else
    begin
      hold_cnt <= RST_OE_N_O ? 0 : hold_cnt + 1;
      mr_cnt   <= (!RST_I && RST_OE_N_O) ? mr_cnt + 1 : 0;
    end
  end

  // slack of 8 covers the three-flop input sync
  property p_low_rst;
    $rose(LOW_SUPPLY_I) |-> ##[1:8] !RST_OE_N_O;
  endproperty
  a_low_rst: assert property (p_low_rst) else $error("low supply no reset");
  property p_hold;
    $rose(RST_OE_N_O) |-> hold_cnt >= HOLD_CYCLES - 1;
  endproperty
  a_hold: assert property (p_hold) else $error("reset hold too short");
  property p_mr;
    mr_cnt > DEBOUNCE_CYCLES + 8 |-> !RST_OE_N_O;
  endproperty
  a_mr: assert property (p_mr) else $error("manual reset ignored");
  property p_drive;
    !RST_O;
  endproperty
  a_drive: assert property (p_drive) else $error("reset pin driven high");
  property p_pf;
    $rose(POWERFAIL_COMPARE_IN_I) |-> ##[2:8] POWERFAIL_WARN_OUT_O;
  endproperty
  a_pf: assert property (p_pf) else $error("warn pin late");
  property p_ready_lat;
    PSEL_I && $rose(PENABLE_I) |=> PREADY_O;
  endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("pready late");
  property p_ready_one;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready too long");
  property p_err;
    PSLVERR_O |-> PREADY_O;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
endmodule : supervisor_chk
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// supervisor testbench
// ********************************
module testbench;
  localparam int HOLD = 20;
  logic        clk     = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        low     = 1'b0;
  logic        pf      = 1'b0;
  logic        ev1     = 1'b0;
  logic        ev2     = 1'b0;
  logic        press   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rst_o;
  logic        oe_n;
  logic        irq;
  logic        warn;
  logic [1:0]  trip;
  logic        pin;
  logic [31:0] rd;
  logic        rd_err;
  int          err_count   = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  processor_companion_supervisor #(.HOLD_CYCLES(HOLD),
    .WD_UNIT_CYCLES(10), .DEBOUNCE_CYCLES(16), .CAL_HALF_CYCLES(4))
    processor_companion_supervisor_i (.CLOCK_I(clk), .ARST_N_I(arst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RST_I(pin), .RST_O(rst_o),
    .RST_OE_N_O(oe_n), .LOW_SUPPLY_I(low), .TRIP_SEL_O(trip),
    .POWERFAIL_COMPARE_IN_I(pf), .POWERFAIL_WARN_OUT_O(warn),
    .EVENT_IN_ONE_I(ev1), .EVENT_IN_TWO_I(ev2), .IRQ_O(irq));

  reset_line_model reset_line_model_i (.drive_n_i(oe_n),
    .press_i(press), .pin_o(pin));

  // clock and a ceiling against hangs
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : chk

  // returns right after a rising edge; outputs read are pre-edge values
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // pready sampled at the rising edge; data taken and request dropped there
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd      = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_power_up();
    wt(1);
    chk("oe_n hold", 0, oe_n);
    apb(0, 8'h00, 0);
    chk("ctrl reset", 32'h2, rd);
    wt(HOLD + 10);
    chk("oe_n free", 1, oe_n);
    apb(0, 8'h40, 0);
    chk("unmapped", 1, rd_err);
  endtask : t_power_up

  task automatic t_serial();
    apb(1, 8'h1c, 32'ha5a5_0001);
    apb(1, 8'h20, 32'h5a5a_0002);
    apb(0, 8'h20, 0);
    chk("serial hi", 32'h5a5a_0002, rd);
    apb(1, 8'h00, 32'he02);
    apb(1, 8'h1c, 32'h0);
    chk("trip", 32'h3, trip);
    apb(0, 8'h1c, 0);
    chk("serial locked", 32'ha5a5_0001, rd);
  endtask : t_serial

  task automatic t_pf_irq();
    logic w0;
    @(posedge clk);
    pf <= 1'b1;
    wt(10);
    chk("warn", 1, warn);
    chk("irq masked", 0, irq);
    apb(1, 8'h0c, 32'h1);
    wt(3);
    chk("irq", 1, irq);
    apb(0, 8'h10, 0);
    chk("pf live", 1, rd[3]);
    apb(0, 8'h08, 0);
    chk("status pf", 1, rd[0]);
    wt(3);
    chk("irq cleared", 0, irq);
    // calibration: the warn pin toggles every four cycles here
    apb(1, 8'h00, 32'h102);
    wt(2);
    w0 = warn;
    wt(4);
    chk("cal wave", {31'h0, ~w0}, warn);
    apb(1, 8'h00, 32'h002);
    apb(1, 8'h0c, 32'h0);
    pf <= 1'b0;
  endtask : t_pf_irq

  task automatic t_counters();
    logic [15:0] c1;
    logic [15:0] c2;
    apb(1, 8'h00, 32'h082);
    apb(0, 8'h14, 0);
    c1 = rd[15:0];
    apb(0, 8'h18, 0);
    c2 = rd[15:0];
    // channel two ends high, so rising counts would give three
    for (int i = 0; i < 3; i++)
    begin
      ev1 <= 1'b1;
      ev2 <= 1'b1;
      wt(6);
      ev1 <= 1'b0;
      if (i < 2)
        ev2 <= 1'b0;
      wt(6);
    end
    apb(0, 8'h14, 0);
    chk("count one", c1 + 16'h3, rd[15:0]);
    apb(0, 8'h18, 0);
    chk("count two", c2 + 16'h2, rd[15:0]);
    ev2 <= 1'b0;
  endtask : t_counters

  task automatic t_low_supply();
    apb(1, 8'h10, 32'h7);
    low <= 1'b1;
    wt(10);
    chk("low drive", 0, oe_n);
    apb(0, 8'h10, 0);
    chk("low flag", 1, rd[1]);
    wt(40);
    low <= 1'b0;
    wt(HOLD - 2);
    chk("low hold", 0, oe_n);
    wt(20);
    chk("low free", 1, oe_n);
    apb(0, 8'h10, 0);
    chk("flag kept", 1, rd[1]);
    apb(1, 8'h10, 32'h2);
    apb(0, 8'h10, 0);
    chk("flag clear", 0, rd[1]);
  endtask : t_low_supply

  task automatic t_manual();
    press <= 1'b1;
    wt(8);
    chk("pin pulled", 0, pin);
    press <= 1'b0;
    wt(10);
    chk("glitch", 1, oe_n);
    press <= 1'b1;
    wt(30);
    press <= 1'b0;
    chk("manual", 0, oe_n);
    wt(HOLD + 10);
    chk("manual free", 1, oe_n);
    apb(0, 8'h10, 0);
    chk("manual flag", 1, rd[2]);
  endtask : t_manual

  task automatic t_watchdog();
    // the field reads back raw; only the timer clamps it
    apb(1, 8'h00, 32'h3e);
    apb(0, 8'h00, 0);
    chk("period max", 5'h1f, rd[5:1]);
    apb(1, 8'h00, 32'h0);
    apb(0, 8'h00, 0);
    chk("period min", 5'h00, rd[5:1]);
    wt(100);
    chk("wd off", 1, oe_n);
    // field zero acts as one unit of ten cycles
    apb(1, 8'h00, 32'h1);
    wt(8);
    chk("wd min fed", 1, oe_n);
    wt(4);
    chk("wd min bite", 0, oe_n);
    apb(1, 8'h00, 32'h5);
    apb(1, 8'h10, 32'h7);
    repeat (6)
    begin
      wt(12);
      apb(1, 8'h04, 32'h0);
    end
    wt(16);
    chk("wd fed", 1, oe_n);
    wt(8);
    chk("wd bite", 0, oe_n);
    apb(0, 8'h10, 0);
    chk("wd flag", 1, rd[0]);
    apb(1, 8'h00, 32'h0);
    wt(HOLD + 10);
    chk("wd free", 1, oe_n);
  endtask : t_watchdog

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_power_up();
    t_serial();
    t_pf_irq();
    t_counters();
    t_low_supply();
    t_manual();
    t_watchdog();
    end_of_test();
  end
endmodule : testbench

bind processor_companion_supervisor supervisor_chk
  #(.HOLD_CYCLES(HOLD_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
  supervisor_chk_i (.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .RST_I(RST_I), .RST_O(RST_O),
  .RST_OE_N_O(RST_OE_N_O), .LOW_SUPPLY_I(LOW_SUPPLY_I),
  .POWERFAIL_COMPARE_IN_I(POWERFAIL_COMPARE_IN_I),
  .POWERFAIL_WARN_OUT_O(POWERFAIL_WARN_OUT_O));
`default_nettype wire
